//--- logic/pmcs_pkg.sv
// Constants and types for the power-mode clock sequencer
package pmcs_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned IRC_START_US = 60;
    localparam int unsigned FLASH_START_US = 100;
    localparam int unsigned IRC_START_CYC = (IRC_START_US * (CLK_HZ / 1000000));
    localparam int unsigned FLASH_START_CYC = (FLASH_START_US * (CLK_HZ / 1000000));
    localparam int unsigned IRC_RESUME_CYC = 4;
    localparam int unsigned MAIN_RESUME_CYC = 4096;
    localparam int unsigned MAIN_STABLE_CYC = 4096;
    localparam int unsigned CNT_W = 13;

    // Register map, word offsets of the plain register port
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PLL_CFG = 4'h1;
    localparam logic [3:0] ADDR_MODE = 4'h2;
    localparam logic [3:0] ADDR_CDIV = 4'h3;
    localparam logic [3:0] ADDR_PGATE = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;
    localparam logic [3:0] ADDR_PDIV = 4'h6;

    // Control register fields
    localparam int unsigned CTRL_PLL_EN = 0;
    localparam int unsigned CTRL_PLL_CONN = 1;
    localparam int unsigned CTRL_SRC_LSB = 2;
    localparam int unsigned CTRL_MAIN_OSC_EN = 4;

    // PLL config: divider minus one in [7:0], multiplier minus one in [22:8]
    localparam int unsigned PLL_N_LSB = 0;
    localparam int unsigned PLL_M_LSB = 8;
    localparam logic [7:0] PLL_N_RST = 8'h00;
    localparam logic [14:0] PLL_M_RST = 15'h0000;
    localparam logic [7:0] CDIV_RST = 8'h00;
    localparam logic [31:0] PGATE_RST = 32'hffffffff;

    typedef enum logic [1:0] {
        PMCS_SRC_IRC = 2'h0,
        PMCS_SRC_MAIN = 2'h1,
        PMCS_SRC_RTC = 2'h2
    } pmcs_src_e;

    typedef enum logic [2:0] {
        PMCS_MODE_RUN = 3'h0,
        PMCS_MODE_IDLE = 3'h1,
        PMCS_MODE_SLEEP = 3'h2,
        PMCS_MODE_PDOWN = 3'h3,
        PMCS_MODE_DPDOWN = 3'h4
    } pmcs_mode_e;

    // Gray codes along RUN -> LOWPWR -> OSC_START -> RESUME -> RUN
    typedef enum logic [2:0] {
        PMCS_ST_RUN = 3'b000,
        PMCS_ST_IDLE = 3'b100,
        PMCS_ST_LOWPWR = 3'b001,
        PMCS_ST_OSC_START = 3'b011,
        PMCS_ST_RESUME = 3'b010,
        PMCS_ST_DEEP = 3'b110
    } pmcs_state_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pmcs_req_s;

    typedef struct packed {
        logic pll_power;
        logic pll_connect;
        logic [7:0] pll_div_n;
        logic [14:0] pll_mul_m;
        logic [7:0] core_div;
        logic [7:0] usb_div;
    } pmcs_pll_s;
endpackage

//--- logic/pmcs_sequencer.sv
// Power-mode clock sequencer: PLL setup, low-power modes and wake timing
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module pmcs_sequencer #(
    parameter int unsigned NUM_PERIPH = 8,
    parameter int unsigned IRC_START_CYCLES = pmcs_pkg::IRC_START_CYC,
    parameter int unsigned FLASH_START_CYCLES = pmcs_pkg::FLASH_START_CYC,
    parameter int unsigned MAIN_RESUME_CYCLES = pmcs_pkg::MAIN_RESUME_CYC,
    parameter int unsigned MAIN_STABLE_CYCLES = pmcs_pkg::MAIN_STABLE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire pmcs_pkg::pmcs_req_s bus_req,
    output logic [31:0] rd_data,

    input wire logic pll_lock,
    input wire logic periph_irq,
    input wire logic clockless_irq,
    input wire logic rtc_alarm,

    output pmcs_pkg::pmcs_pll_s pll_cfg,
    output logic [1:0] clk_src_sel,
    output logic cpu_run,

    output logic internal_clk_en,
    output logic internal_rc_oscillator_power,
    output logic internal_rc_oscillator_out_en,
    output logic main_osc_ok,
    output logic flash_power,
    output logic flash_ready,
    output logic regulator_on,
    output logic rtc_osc_run,
    output logic power_restore,
    output logic [NUM_PERIPH-1:0] periph_clk_en,
    output logic [NUM_PERIPH*8-1:0] periph_div
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    pmcs_pkg::pmcs_state_e state_reg;

    logic pll_en_reg;
    logic pll_conn_reg;
    logic [1:0] src_reg;
    logic main_osc_en_reg;
    logic [7:0] pll_n_reg;
    logic [14:0] pll_m_reg;
    logic [7:0] core_div_reg;
    logic [7:0] usb_div_reg;

    logic [NUM_PERIPH-1:0] pgate_reg;
    logic [NUM_PERIPH*8-1:0] pdiv_reg;

    logic [pmcs_pkg::CNT_W-1:0] wake_cnt_reg;
    logic [pmcs_pkg::CNT_W-1:0] stab_cnt_reg;
    logic [pmcs_pkg::CNT_W-1:0] flash_cnt_reg;

    logic main_ok_reg;
    logic flash_rdy_reg;
    logic flash_pwr_reg;
    logic rc_pwr_reg;
    logic pd_wake_reg;
    logic main_src_at_entry_reg;

    logic [31:0] rd_data_reg;

    logic wr_ctrl;
    logic wr_mode;
    logic [2:0] mode_req;

    logic wake_sleep;
    logic enter_sleep;
    logic enter_pdown;

    logic resume_done;
    logic [pmcs_pkg::CNT_W-1:0] resume_len;

    assign wr_ctrl = bus_req.wr && (bus_req.addr == pmcs_pkg::ADDR_CTRL);
    assign wr_mode = bus_req.wr && (bus_req.addr == pmcs_pkg::ADDR_MODE);
    assign mode_req = bus_req.wdata[2:0];

    assign enter_sleep = wr_mode && (state_reg == pmcs_pkg::PMCS_ST_RUN)
        && (mode_req == pmcs_pkg::PMCS_MODE_SLEEP);
    assign enter_pdown = wr_mode && (state_reg == pmcs_pkg::PMCS_ST_RUN)
        && (mode_req == pmcs_pkg::PMCS_MODE_PDOWN);

    assign wake_sleep = clockless_irq || rtc_alarm;

    // Resume length follows the clock source in use at sleep entry; a power-down wake always uses the RC length
    assign resume_len = main_src_at_entry_reg
        ? pmcs_pkg::CNT_W'(MAIN_RESUME_CYCLES - 1)
        : pmcs_pkg::CNT_W'(pmcs_pkg::IRC_RESUME_CYC - 1);
    assign resume_done = (state_reg == pmcs_pkg::PMCS_ST_RESUME)
        && (wake_cnt_reg == resume_len);

    // ------------------------------------------------------------
    // Mode sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= pmcs_pkg::PMCS_ST_RUN;
            wake_cnt_reg <= '0;
            pd_wake_reg <= 1'b0;
            main_src_at_entry_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                pmcs_pkg::PMCS_ST_RUN: begin
                    wake_cnt_reg <= '0;
                    if (wr_mode) begin
                        unique case (mode_req)
                            pmcs_pkg::PMCS_MODE_IDLE: begin
                                state_reg <= pmcs_pkg::PMCS_ST_IDLE;
                            end
                            pmcs_pkg::PMCS_MODE_SLEEP, pmcs_pkg::PMCS_MODE_PDOWN: begin
                                state_reg <= pmcs_pkg::PMCS_ST_LOWPWR;
                                pd_wake_reg <= enter_pdown;
                                main_src_at_entry_reg <= (src_reg == pmcs_pkg::PMCS_SRC_MAIN);
                            end
                            pmcs_pkg::PMCS_MODE_DPDOWN: begin
                                state_reg <= pmcs_pkg::PMCS_ST_DEEP;
                            end
                            default: begin
                                state_reg <= pmcs_pkg::PMCS_ST_RUN;
                            end
                        endcase
                    end
                end

                pmcs_pkg::PMCS_ST_IDLE: begin
                    if (periph_irq || wake_sleep) begin
                        state_reg <= pmcs_pkg::PMCS_ST_RUN;
                    end
                end

                pmcs_pkg::PMCS_ST_LOWPWR: begin
                    wake_cnt_reg <= '0;
                    if (wake_sleep) begin
                        // Power-down always wakes on the RC oscillator
                        state_reg <= pd_wake_reg ? pmcs_pkg::PMCS_ST_OSC_START
                                                 : pmcs_pkg::PMCS_ST_RESUME;
                        if (pd_wake_reg) begin
                            main_src_at_entry_reg <= 1'b0;
                        end
                    end
                end

                pmcs_pkg::PMCS_ST_OSC_START: begin
                    if (wake_cnt_reg == pmcs_pkg::CNT_W'(IRC_START_CYCLES - 1)) begin
                        wake_cnt_reg <= '0;
                        state_reg <= pmcs_pkg::PMCS_ST_RESUME;
                    end else begin
                        wake_cnt_reg <= wake_cnt_reg + 1'b1;
                    end
                end

                pmcs_pkg::PMCS_ST_RESUME: begin
                    if (resume_done) begin
                        wake_cnt_reg <= '0;
                        state_reg <= pmcs_pkg::PMCS_ST_RUN;
                    end else begin
                        wake_cnt_reg <= wake_cnt_reg + 1'b1;
                    end
                end

                pmcs_pkg::PMCS_ST_DEEP: begin
                    // Nothing retained; only rst_n leaves here, rtc_alarm does not
                    state_reg <= pmcs_pkg::PMCS_ST_DEEP;
                end

                default: begin
                    state_reg <= pmcs_pkg::PMCS_ST_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Clock control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_en_reg <= 1'b0;
            pll_conn_reg <= 1'b0;
            src_reg <= pmcs_pkg::PMCS_SRC_IRC;
            main_osc_en_reg <= 1'b0;
            core_div_reg <= pmcs_pkg::CDIV_RST;
            usb_div_reg <= pmcs_pkg::CDIV_RST;
            pll_n_reg <= pmcs_pkg::PLL_N_RST;
            pll_m_reg <= pmcs_pkg::PLL_M_RST;
        end else if (enter_sleep || enter_pdown) begin
            pll_en_reg <= 1'b0;
            pll_conn_reg <= 1'b0;
            core_div_reg <= '0;
            usb_div_reg <= '0;
            if (enter_pdown) begin
                src_reg <= pmcs_pkg::PMCS_SRC_IRC;
            end
        end else if (bus_req.wr) begin
            if (wr_ctrl) begin
                pll_en_reg <= bus_req.wdata[pmcs_pkg::CTRL_PLL_EN];
                // Connect only takes when enabled and locked
                pll_conn_reg <= bus_req.wdata[pmcs_pkg::CTRL_PLL_CONN]
                    && bus_req.wdata[pmcs_pkg::CTRL_PLL_EN] && pll_lock;
                src_reg <= bus_req.wdata[pmcs_pkg::CTRL_SRC_LSB +: 2];
                main_osc_en_reg <= bus_req.wdata[pmcs_pkg::CTRL_MAIN_OSC_EN];
            end

            if (bus_req.addr == pmcs_pkg::ADDR_PLL_CFG) begin
                pll_n_reg <= bus_req.wdata[pmcs_pkg::PLL_N_LSB +: 8];
                pll_m_reg <= bus_req.wdata[pmcs_pkg::PLL_M_LSB +: 15];
            end

            if (bus_req.addr == pmcs_pkg::ADDR_CDIV) begin
                core_div_reg <= bus_req.wdata[7:0];
                usb_div_reg <= bus_req.wdata[15:8];
            end
        end else if (!pll_lock) begin
            pll_conn_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Peripheral gates and dividers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pgate_reg <= pmcs_pkg::PGATE_RST[NUM_PERIPH-1:0];
            pdiv_reg <= '0;
        end else begin
            if (bus_req.wr && bus_req.addr == pmcs_pkg::ADDR_PGATE) begin
                pgate_reg <= bus_req.wdata[NUM_PERIPH-1:0];
            end

            // Divider write: index in [31:24], value in [7:0]
            for (int i = 0; i < NUM_PERIPH; i++) begin
                if (bus_req.wr && bus_req.addr == pmcs_pkg::ADDR_PDIV
                    && bus_req.wdata[31:24] == 8'(i)) begin
                    pdiv_reg[i*8 +: 8] <= bus_req.wdata[7:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Main oscillator stability and flash wake timers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stab_cnt_reg <= '0;
            main_ok_reg <= 1'b0;
        end else if (!main_osc_en_reg || state_reg == pmcs_pkg::PMCS_ST_OSC_START) begin
            stab_cnt_reg <= '0;
            main_ok_reg <= 1'b0;
        end else if (!main_ok_reg) begin
            if (stab_cnt_reg == pmcs_pkg::CNT_W'(MAIN_STABLE_CYCLES - 1)) begin
                main_ok_reg <= 1'b1;
            end else begin
                stab_cnt_reg <= stab_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_pwr_reg <= 1'b1;
            rc_pwr_reg <= 1'b1;
            flash_rdy_reg <= 1'b1;
            flash_cnt_reg <= '0;
        end else if (enter_pdown) begin
            flash_pwr_reg <= 1'b0;
            rc_pwr_reg <= 1'b0;
            flash_rdy_reg <= 1'b0;
        end else if (state_reg == pmcs_pkg::PMCS_ST_LOWPWR && wake_sleep
                     && pd_wake_reg) begin
            flash_pwr_reg <= 1'b1;
            rc_pwr_reg <= 1'b1;
            flash_cnt_reg <= '0;
        end else if (flash_pwr_reg && !flash_rdy_reg
                     && state_reg != pmcs_pkg::PMCS_ST_LOWPWR) begin
            // Counting starts with RC start-up, so it overlaps it
            if (flash_cnt_reg == pmcs_pkg::CNT_W'(FLASH_START_CYCLES - 1)) begin
                flash_rdy_reg <= 1'b1;
            end else begin
                flash_cnt_reg <= flash_cnt_reg + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= '0;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                pmcs_pkg::ADDR_CTRL:
                    rd_data_reg <= {27'h0, main_osc_en_reg, src_reg, pll_conn_reg, pll_en_reg};
                pmcs_pkg::ADDR_PLL_CFG:
                    rd_data_reg <= {9'h0, pll_m_reg, pll_n_reg};
                pmcs_pkg::ADDR_MODE:
                    rd_data_reg <= {29'h0, state_reg};
                pmcs_pkg::ADDR_CDIV:
                    rd_data_reg <= {16'h0, usb_div_reg, core_div_reg};
                pmcs_pkg::ADDR_PGATE:
                    rd_data_reg <= 32'(pgate_reg);
                pmcs_pkg::ADDR_STATUS:
                    rd_data_reg <= {28'h0, flash_rdy_reg, main_ok_reg, pll_lock,
                                    pll_conn_reg && pll_en_reg};
                default:
                    rd_data_reg <= '0;
            endcase
        end else begin
            rd_data_reg <= '0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rd_data = rd_data_reg;

    assign pll_cfg.pll_power = pll_en_reg;
    assign pll_cfg.pll_connect = pll_en_reg && pll_conn_reg;
    assign pll_cfg.pll_div_n = pll_n_reg;
    assign pll_cfg.pll_mul_m = pll_m_reg;
    assign pll_cfg.core_div = core_div_reg;
    assign pll_cfg.usb_div = usb_div_reg;

    assign clk_src_sel = src_reg;

    assign cpu_run = (state_reg == pmcs_pkg::PMCS_ST_RUN);
    assign internal_clk_en = (state_reg == pmcs_pkg::PMCS_ST_RUN)
        || (state_reg == pmcs_pkg::PMCS_ST_IDLE);
    assign internal_rc_oscillator_power = rc_pwr_reg
        && (state_reg != pmcs_pkg::PMCS_ST_DEEP);
    assign internal_rc_oscillator_out_en = rc_pwr_reg
        && (state_reg != pmcs_pkg::PMCS_ST_LOWPWR)
        && (state_reg != pmcs_pkg::PMCS_ST_DEEP);

    assign main_osc_ok = main_ok_reg;
    assign flash_power = flash_pwr_reg && (state_reg != pmcs_pkg::PMCS_ST_DEEP);
    assign flash_ready = flash_rdy_reg && flash_power;

    assign regulator_on = (state_reg != pmcs_pkg::PMCS_ST_DEEP);
    assign rtc_osc_run = 1'b1;
    assign power_restore = rtc_alarm;

    assign periph_clk_en = internal_clk_en ? pgate_reg : '0;
    assign periph_div = pdiv_reg;
endmodule

//--- tb/pmcs_pll_model.sv
// PLL far side: reports lock a fixed time after the PLL is powered
`timescale 1ns/1ns
module pmcs_pll_model #(
    parameter int unsigned LOCK_CYCLES = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pll_power,
    output logic pll_lock
);
    int cnt;
    // Lock drops on the first clock edge after power goes low, so it trails pll_power by one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            pll_lock <= 1'b0;
        end else if (!pll_power) begin
            cnt <= 0;
            pll_lock <= 1'b0;
        end else if (cnt == LOCK_CYCLES) begin
            pll_lock <= 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

//--- tb/pmcs_sequencer_props.sv
// Port assertions for the power-mode clock sequencer
`timescale 1ns/1ns
module pmcs_sequencer_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pll_lock,
    input wire pmcs_pkg::pmcs_req_s bus_req,
    input wire pmcs_pkg::pmcs_pll_s pll_cfg,
    input wire logic [1:0] clk_src_sel,
    input wire logic cpu_run,
    input wire logic internal_clk_en,
    input wire logic internal_rc_oscillator_power,
    input wire logic internal_rc_oscillator_out_en,
    input wire logic flash_power,
    input wire logic flash_ready,
    input wire logic regulator_on,
    input wire logic rtc_osc_run,
    input wire logic rtc_alarm,
    input wire logic power_restore,
    input wire logic [7:0] periph_clk_en
);
    logic mw;
    logic [2:0] md;
    assign mw = bus_req.wr && bus_req.addr == pmcs_pkg::ADDR_MODE && cpu_run;
    assign md = bus_req.wdata[2:0];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_sleep_pll_off: assert property (mw && md == 3'h2 |=>
        !pll_cfg.pll_power && !pll_cfg.pll_connect && pll_cfg.core_div == 8'h00
        && pll_cfg.usb_div == 8'h00) else $error("sleep pll");
    chk_sleep_clocks: assert property (mw && md == 3'h2 |=> !cpu_run &&
        !internal_clk_en && internal_rc_oscillator_power && !internal_rc_oscillator_out_en
        && flash_power) else $error("sleep clocks");
    chk_pdown_power: assert property (mw && md == 3'h3 |=> !pll_cfg.pll_power &&
        clk_src_sel == 2'h0 && !internal_rc_oscillator_power && !flash_power && !flash_ready)
        else $error("pdown power");
    chk_idle_halt: assert property (mw && md == 3'h1 |=> !cpu_run && internal_clk_en)
        else $error("idle");
    chk_deep_entry: assert property (mw && md == 3'h4 |=> !regulator_on && !cpu_run)
        else $error("deep entry");
    chk_deep_stays: assert property (!regulator_on |=> !regulator_on)
        else $error("deep exit");
    chk_pll_connect: assert property ($rose(pll_cfg.pll_connect) |-> $past(pll_lock))
        else $error("connect");
    chk_alarm_out: assert property (power_restore == rtc_alarm && rtc_osc_run)
        else $error("alarm");
    chk_gate_off: assert property (!internal_clk_en |-> periph_clk_en == 8'h00)
        else $error("gates");
    chk_reset_exit: assert property ($rose(rst_n) |-> !pll_cfg.pll_power &&
        clk_src_sel == 2'h0 && cpu_run) else $error("reset");
    chk_flash_wait: assert property ($rose(flash_ready) |-> $past(flash_power, 8))
        else $error("flash");
endmodule
bind pmcs_sequencer pmcs_sequencer_props u_props (.clk(clk), .rst_n(rst_n), .pll_lock(pll_lock),
    .bus_req(bus_req), .pll_cfg(pll_cfg), .clk_src_sel(clk_src_sel), .cpu_run(cpu_run),
    .internal_clk_en(internal_clk_en),
    .internal_rc_oscillator_power(internal_rc_oscillator_power),
    .internal_rc_oscillator_out_en(internal_rc_oscillator_out_en),
    .flash_power(flash_power), .flash_ready(flash_ready), .regulator_on(regulator_on),
    .rtc_osc_run(rtc_osc_run), .rtc_alarm(rtc_alarm), .power_restore(power_restore),
    .periph_clk_en(periph_clk_en));

//--- tb/tb_pmcs_sequencer.sv
// Self-checking testbench for the power-mode clock sequencer
`timescale 1ns/1ns
module tb_pmcs_sequencer;
    // Short counts keep the wake waits brief
    localparam int IRC_N = 12;
    localparam int FLASH_N = 16;
    localparam int MRES_N = 10;
    localparam int MST_N = 8;
    logic clk, rst_n, pll_lock, periph_irq, clockless_irq, rtc_alarm;
    pmcs_pkg::pmcs_req_s bus_req;
    pmcs_pkg::pmcs_pll_s pll_cfg;
    logic [31:0] rd_data;
    logic [1:0] clk_src_sel;
    logic cpu_run, internal_clk_en, rc_pwr, rc_out, main_osc_ok, flash_power, flash_ready;
    logic regulator_on, rtc_osc_run, power_restore;
    logic [7:0] periph_clk_en;
    logic [63:0] periph_div;
    int errors, samples_checked, cycles;
    pmcs_sequencer #(.IRC_START_CYCLES(IRC_N), .FLASH_START_CYCLES(FLASH_N),
        .MAIN_RESUME_CYCLES(MRES_N), .MAIN_STABLE_CYCLES(MST_N)) u_pmcs_sequencer (
        .clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data), .pll_lock(pll_lock),
        .periph_irq(periph_irq), .clockless_irq(clockless_irq), .rtc_alarm(rtc_alarm),
        .pll_cfg(pll_cfg), .clk_src_sel(clk_src_sel), .cpu_run(cpu_run),
        .internal_clk_en(internal_clk_en), .internal_rc_oscillator_power(rc_pwr),
        .internal_rc_oscillator_out_en(rc_out), .main_osc_ok(main_osc_ok),
        .flash_power(flash_power), .flash_ready(flash_ready), .regulator_on(regulator_on),
        .rtc_osc_run(rtc_osc_run), .power_restore(power_restore),
        .periph_clk_en(periph_clk_en), .periph_div(periph_div));
    pmcs_pll_model u_pmcs_pll_model (.clk(clk), .rst_n(rst_n),
        .pll_power(pll_cfg.pll_power), .pll_lock(pll_lock));
    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rng(input string nm, input int n, input int lo);
        chk(nm, 32'(lo), (n >= lo && n <= lo + 2) ? 32'(lo) : 32'(n));
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk) bus_req.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk) bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk) bus_req.rd <= 1'b0;
        #1 d = rd_data;
    endtask
    // Edges seen until cpu_run (0) or flash_ready (1) goes high
    task automatic wait_n(input int w, output int n);
        n = 0;
        while (((w == 0) ? cpu_run : flash_ready) !== 1'b1 && n < 5000) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    task automatic get_lock;
        for (int i = 0; i < 40 && pll_lock !== 1'b1; i++) @(posedge clk);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        logic [31:0] d;
        chk("pll_power", 0, pll_cfg.pll_power);
        chk("src", 0, clk_src_sel);
        chk("osc_ok", 0, main_osc_ok);
        wr(pmcs_pkg::ADDR_PGATE, 32'h5);
        chk("gates", 32'h5, periph_clk_en);
        rd(pmcs_pkg::ADDR_PGATE, d);
        chk("gates rd", 32'h5, d);
        wr(pmcs_pkg::ADDR_PDIV, 32'h0300002a);
        chk("pdiv", 32'h2a, periph_div[31:24]);
        rd(pmcs_pkg::ADDR_PDIV, d);
        chk("pdiv rd", 0, d);
        wr(4'hf, 32'hffffffff);
        rd(4'hf, d);
        chk("unmapped", 0, d);
        $display("test regs done");
    endtask
    task automatic t_pll;
        logic [31:0] d;
        wr(pmcs_pkg::ADDR_PLL_CFG, 32'h007fffff);
        chk("div n", 8'hff, pll_cfg.pll_div_n);
        chk("mul m", 15'h7fff, pll_cfg.pll_mul_m);
        // 4 MHz times 100 over 1 puts the oscillator at 400 MHz
        wr(pmcs_pkg::ADDR_PLL_CFG, 32'h00006300);
        chk("div n", 0, pll_cfg.pll_div_n);
        rd(pmcs_pkg::ADDR_PLL_CFG, d);
        chk("pll rd", 32'h6300, d);
        wr(pmcs_pkg::ADDR_CTRL, 32'h3);
        chk("early conn", 0, pll_cfg.pll_connect);
        get_lock();
        wr(pmcs_pkg::ADDR_CTRL, 32'h13);
        chk("conn", 1, pll_cfg.pll_connect);
        rd(pmcs_pkg::ADDR_STATUS, d);
        chk("active", 1, d[0]);
        $display("test pll done");
    endtask
    task automatic t_main;
        int n;
        n = 0;
        while (main_osc_ok !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1 n++;
        end
        rng("osc wait", n, MST_N - 2);
        $display("test main done");
    endtask
    task automatic t_idle;
        int n;
        wr(pmcs_pkg::ADDR_MODE, 32'h1);
        chk("idle run", 0, cpu_run);
        chk("idle gates", 32'h5, periph_clk_en);
        @(posedge clk) periph_irq <= 1'b1;
        wait_n(0, n);
        @(posedge clk) periph_irq <= 1'b0;
        chk("idle wake", 1, n >= 1 && n <= 8);
        $display("test idle done");
    endtask
    task automatic t_sleep(input logic main);
        int n;
        logic [31:0] d;
        wr(pmcs_pkg::ADDR_CTRL, 32'h11);
        get_lock();
        wr(pmcs_pkg::ADDR_CTRL, main ? 32'h17 : 32'h13);
        rd(pmcs_pkg::ADDR_CTRL, d);
        chk("ctrl rd", main ? 32'h17 : 32'h13, d);
        wr(pmcs_pkg::ADDR_CDIV, 32'h0305);
        rd(pmcs_pkg::ADDR_CDIV, d);
        chk("cdiv rd", 32'h305, d);
        wr(pmcs_pkg::ADDR_MODE, 32'h2);
        chk("sleep conn", 0, pll_cfg.pll_connect);
        chk("sleep div", 0, {pll_cfg.core_div, pll_cfg.usb_div});
        chk("rc gate", 32'h2, {rc_pwr, rc_out});
        chk("flash", 1, flash_power);
        rd(pmcs_pkg::ADDR_MODE, d);
        chk("mode rd", 32'h1, d);
        @(posedge clk) periph_irq <= 1'b1;
        repeat (6) @(posedge clk);
        periph_irq <= 1'b0;
        #1 chk("no wake", 0, cpu_run);
        @(posedge clk) clockless_irq <= 1'b1;
        wait_n(0, n);
        @(posedge clk) clockless_irq <= 1'b0;
        rng("sleep wake", n, main ? MRES_N : 4);
        $display("test sleep done");
    endtask
    task automatic t_pdown;
        int n1, n2;
        // Two rounds show the wake counters restart each time
        for (int k = 0; k < 2; k++) begin
            wr(pmcs_pkg::ADDR_CTRL, 32'h15);
            wr(pmcs_pkg::ADDR_MODE, 32'h3);
            chk("pd pll", 0, pll_cfg.pll_power);
            chk("pd src", 0, clk_src_sel);
            chk("pd power", 0, {rc_pwr, flash_power, flash_ready});
            @(posedge clk) rtc_alarm <= 1'b1;
            fork
                wait_n(0, n1);
                wait_n(1, n2);
            join
            @(posedge clk) rtc_alarm <= 1'b0;
            rng("pd wake", n1, IRC_N + 4);
            rng("pd flash", n2, FLASH_N);
        end
        $display("test pdown done");
    endtask
    task automatic t_deep;
        wr(pmcs_pkg::ADDR_MODE, 32'h4);
        chk("deep reg", 0, regulator_on);
        @(posedge clk) rtc_alarm <= 1'b1;
        repeat (6) @(posedge clk);
        rtc_alarm <= 1'b0;
        #1 chk("deep stay", 0, {regulator_on, cpu_run});
        @(posedge clk) rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk("deep exit", 32'h6, {regulator_on, cpu_run, pll_cfg.pll_power});
        $display("test deep done");
    endtask
    // ----------------------------------------
    // Clock, reset, sequence and timeout
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        rst_n = 1'b0;
        bus_req = '0;
        periph_irq = 1'b0;
        clockless_irq = 1'b0;
        rtc_alarm = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_pll();
        t_main();
        t_idle();
        t_sleep(1'b0);
        t_sleep(1'b1);
        t_pdown();
        t_deep();
        test_done();
    end
endmodule
